// file: design/adc_fifo_pkg.sv
// Purpose: shared constants and carriers for the result fifo serial readout block
// Assumes: 100 MHz system clock, host-driven serial clock sampled as a pin
// Notes:   entries are 16 bits, four leading zeros then a 12-bit straight-binary code
// How it works
// - chip select raised inside first byte: next byte read gives following 8 bits.
// - first byte complete, second byte partial: rest of entry is dropped.
// - later entries stay intact; host ignores four leading zero bits of each entry.
// - partial register write updates shifted-in bits from msb down, keeps the rest.
// - voltage codes are straight binary, one step is reference over 4096.
// - temperature codes are binary, one step is 0.125 degrees.
// - end-of-conversion stays low from scan end until chip select or convert start low.
// - a requested temperature result enters the fifo before channel results.
// - reset command with bit one empties fifo; with bit zero resets all registers.
package adc_fifo_pkg;
   localparam int          ENTRY_W       = 16;
   localparam int          CODE_W        = 12;
   localparam int          LEAD_W        = 4;
   localparam int          FIFO_DEPTH    = 16;
   localparam int          CFG_REGS      = 4;
   localparam int          CMD_RST_BIT   = 3;
   localparam logic [3:0]  CMD_RST_TAG   = 4'h1;
   localparam int          CMD_SEL_HI    = 7;
   localparam int          CMD_SEL_LO    = 4;
   localparam logic [7:0]  CFG_RST_VAL   = 8'h00;
   localparam int          BYTE_W        = 8;
   localparam int          VREF_STEPS    = 4096;
   localparam int          TEMP_MDEG_LSB = 125;

   typedef struct packed {
      logic              is_temp;
      logic [CODE_W-1:0] code;
   } result_t;

   typedef enum logic [2:0] {
      SP_IDLE  = 3'b001,
      SP_READ  = 3'b010,
      SP_WRITE = 3'b100
   } sp_state_t;
endpackage

// file: design/skid_buffer.sv
// Purpose: two-entry buffer between the converter core and the result fifo
// Assumes: single clock
// Notes:   full throughput; a stall downstream loses no word
`timescale 1ns/100ps
module skid_buffer
   import adc_fifo_pkg::*;
#(
   parameter int W = 13
)
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][W-1:0] d;
      logic [1:0]        cnt;
      logic              rdy;
   } sk_t;
   sk_t s_r, s_nxt;
   logic push, pop;

   always_comb
   begin
      s_nxt = s_r;
      push  = in_valid && (s_r.cnt != 2'h2);
      pop   = out_ready && (s_r.cnt != 2'h0);
      if (pop)
      begin
         s_nxt.d[0] = s_r.d[1];
      end
      if (push)
      begin
         if (s_r.cnt == 2'h0 || (s_r.cnt == 2'h1 && pop))
         begin
            s_nxt.d[0] = in_data;
         end
         else
         begin
            s_nxt.d[1] = in_data;
         end
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
      // ready is registered so the upstream side sees a flop, not a compare
      s_nxt.rdy = (s_nxt.cnt != 2'h2);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '{d:'0, cnt:2'h0, rdy:1'b1};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign in_ready  = s_r.rdy;
   assign out_valid = (s_r.cnt != 2'h0);
   assign out_data  = s_r.d[0];
endmodule

// file: design/adc_fifo_serial.sv
// Purpose: result fifo and serial port with partial read and write handling
// Assumes: sclk, cs_n, din, convert_start_input are pins; core results arrive on clk
// Notes:   mode-0 serial: data sampled on rising sclk, shifted out on falling sclk
`timescale 1ns/100ps
module adc_fifo_serial
   import adc_fifo_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                cs_n,
   input  wire logic                sclk,
   input  wire logic                din,
   output logic                     dout,
   output logic                     eoc_n,
   input  wire logic                convert_start_input_n,
   input  wire logic                core_valid,
   output logic                     core_ready,
   input  wire result_t             core_data,
   input  wire logic                scan_done,
   output logic                     scan_abort,
   output logic [CFG_REGS-1:0][7:0] cfg
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [2:0]                sy_cs, sy_ck, sy_di, sy_cv;
      logic                      cs, ck, cv;
      sp_state_t                 st;
      logic [4:0]                bits;
      logic [ENTRY_W-1:0]        sh;
      logic [7:0]                wsh;
      logic [1:0]                widx;
      logic                      touched;
      logic                      lost_first;
      logic [PW:0]               rd, wr;
      logic [CFG_REGS-1:0][7:0]  cfg;
      logic                      dout;
      logic                      eoc_n;
      logic                      abort;
   } st_t;

   st_t s_r, s_nxt;
   logic [ENTRY_W-1:0] mem_r [DEPTH];
   logic               bv;
   result_t            bd;
   logic               b_rdy;
   logic               full;
   logic               pin_cs, pin_ck, pin_di, pin_cv;
   logic               ck_rise, ck_fall, cs_fall, cs_rise;
   logic               rst_cmd;
   logic [3:0]         nw;

   skid_buffer #(.W($bits(result_t))) u_buf
   (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (core_valid),
      .in_ready  (core_ready),
      .in_data   (core_data),
      .out_valid (bv),
      .out_ready (b_rdy),
      .out_data  (bd)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sy_cs = {s_r.sy_cs[1:0], cs_n};
      s_nxt.sy_ck = {s_r.sy_ck[1:0], sclk};
      s_nxt.sy_di = {s_r.sy_di[1:0], din};
      s_nxt.sy_cv = {s_r.sy_cv[1:0], convert_start_input_n};
      // a cs, sclk or convert start change counts once stages two and three agree; din is taken from stage three
      pin_cs = (s_r.sy_cs[2] == s_r.sy_cs[1]) ? s_r.sy_cs[2] : s_r.cs;
      pin_ck = (s_r.sy_ck[2] == s_r.sy_ck[1]) ? s_r.sy_ck[2] : s_r.ck;
      pin_di = s_r.sy_di[2];
      pin_cv = (s_r.sy_cv[2] == s_r.sy_cv[1]) ? s_r.sy_cv[2] : s_r.cv;
      s_nxt.cs = pin_cs;
      s_nxt.ck = pin_ck;
      s_nxt.cv = pin_cv;
      ck_rise = pin_ck && !s_r.ck && !pin_cs;
      ck_fall = !pin_ck && s_r.ck && !pin_cs;
      cs_fall = !pin_cs && s_r.cs;
      cs_rise = pin_cs && !s_r.cs;
      full    = (s_r.wr - s_r.rd) == (PW+1)'(DEPTH);
      b_rdy   = 1'b0;
      s_nxt.abort = 1'b0;
      nw      = (s_r.bits > 5'(BYTE_W)) ? 4'(BYTE_W) : s_r.bits[3:0];
      rst_cmd = (s_r.bits >= 5'(BYTE_W)) && (s_r.wsh[CMD_SEL_HI:CMD_SEL_LO] == CMD_RST_TAG);

      // stays low until cs or convert start next falls
      if (scan_done)
      begin
         s_nxt.eoc_n = 1'b0;
      end
      else if (cs_fall || (!pin_cv && s_r.cv))
      begin
         s_nxt.eoc_n = 1'b1;
         // early select kills the running scan; the host is expected to wait
         s_nxt.abort = cs_fall && s_r.eoc_n;
      end

      // temperature ordering is kept by the core feeding it first; codes pass untouched
      if (bv && !full)
      begin
         b_rdy = 1'b1;
         s_nxt.wr = s_r.wr + 1'b1;
      end

      unique case (s_r.st)
         SP_IDLE:
         begin
            s_nxt.dout = 1'b0;
            if (cs_fall)
            begin
               s_nxt.st      = SP_WRITE;
               s_nxt.bits    = '0;
               s_nxt.touched = 1'b0;
               s_nxt.wsh     = '0;
               s_nxt.widx    = '0;
               // leading zeros of the next entry, then 12-bit code
               s_nxt.sh      = (s_r.rd != s_r.wr) ? mem_r[s_r.rd[PW-1:0]] : '0;
               if (s_r.lost_first)
               begin
                  s_nxt.sh = {s_nxt.sh[ENTRY_W-BYTE_W-1:0], 8'h00};
               end
            end
         end
         SP_WRITE, SP_READ:
         begin
            if (ck_rise)
            begin
               s_nxt.bits = s_r.bits + 5'h1;
               // the first byte of every frame is the host's command or register byte
               if (s_r.bits < 5'(BYTE_W))
               begin
                  s_nxt.wsh = {s_r.wsh[6:0], pin_di};
               end
               // register index is the first two bits shifted in
               if (s_r.bits == 5'h1)
               begin
                  s_nxt.widx = {s_r.wsh[0], pin_di};
               end
            end
            // every falling edge shows the next bit; the first one moves the state from SP_WRITE to SP_READ
            if (ck_fall)
            begin
               s_nxt.st      = SP_READ;
               s_nxt.dout    = s_r.sh[ENTRY_W-1];
               s_nxt.sh      = {s_r.sh[ENTRY_W-2:0], 1'b0};
               s_nxt.touched = 1'b1;
            end
            if (cs_rise)
            begin
               s_nxt.st   = SP_IDLE;
               s_nxt.dout = 1'b0;
               if (s_r.touched && s_r.rd != s_r.wr)
               begin
                  if (s_r.bits < 5'(BYTE_W) && !s_r.lost_first)
                  begin
                     // first byte cut short: keep the entry, next read gives next 8 bits
                     s_nxt.lost_first = 1'b1;
                  end
                  else
                  begin
                     s_nxt.rd = s_r.rd + 1'b1;
                     s_nxt.lost_first = 1'b0;
                  end
               end
               // commands act at frame end, so a clear also drops the entry just read
               if (rst_cmd)
               begin
                  s_nxt.rd = s_r.wr;
                  s_nxt.lost_first = 1'b0;
                  if (!s_r.wsh[CMD_RST_BIT])
                  begin
                     s_nxt.cfg = {CFG_REGS{CFG_RST_VAL}};
                  end
               end
               else if (nw != 4'h0)
               begin
                  // merge only the bits shifted so far, msb downward
                  for (int i = 0; i < BYTE_W; i++)
                  begin
                     if (i >= BYTE_W - int'(nw))
                     begin
                        s_nxt.cfg[s_r.widx][i] = s_r.wsh[i - (BYTE_W - int'(nw))];
                     end
                  end
               end
            end
         end
         default:
         begin
            s_nxt.st = SP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '{sy_cs:3'h7, sy_ck:3'h0, sy_di:3'h0, sy_cv:3'h7, cs:1'b1, ck:1'b0,
                  cv:1'b1, st:SP_IDLE, eoc_n:1'b1, cfg:{CFG_REGS{CFG_RST_VAL}},
                  default:'0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // fifo storage has no reset; pointers decide what is valid
   always_ff @(posedge clk)
   begin
      if (b_rdy)
      begin
         mem_r[s_r.wr[PW-1:0]] <= {(LEAD_W)'(0), bd.code};
      end
   end

   assign dout       = s_r.dout;
   assign eoc_n      = s_r.eoc_n;
   assign scan_abort = s_r.abort;
   assign cfg        = s_r.cfg;
endmodule

// file: testbench/adc_fifo_serial_checker.sv
// Purpose: port assertions for the result fifo serial block
// Assumes: pins stay put for several clk cycles between their edges
// Notes:   pin edges reach the logic 3-4 clk late, hence the past depths
`timescale 1ns/100ps
module adc_fifo_serial_checker
   import adc_fifo_pkg::*;
(
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic                cs_n,
   input wire logic                sclk,
   input wire logic                din,
   input wire logic                dout,
   input wire logic                eoc_n,
   input wire logic                convert_start_input_n,
   input wire logic                core_valid,
   input wire logic                core_ready,
   input wire result_t             core_data,
   input wire logic                scan_done,
   input wire logic                scan_abort,
   input wire logic [CFG_REGS-1:0][7:0] cfg
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   eoc_set_a: assert property (scan_done |=> !eoc_n)
      else $error("eoc_n not low after scan end");
   eoc_hold_a: assert property (!eoc_n && cs_n && convert_start_input_n && $past(cs_n, 5)
      && $past(convert_start_input_n, 5) |=> !eoc_n) else $error("eoc_n left low early");
   eoc_rel_a: assert property ($fell(cs_n) && !eoc_n |-> ##[2:7] eoc_n)
      else $error("eoc_n not released by chip select");
   abort_pulse_a: assert property (scan_abort |=> !scan_abort)
      else $error("scan_abort longer than one cycle");
   abort_cause_a: assert property (scan_abort |-> !cs_n && eoc_n)
      else $error("scan_abort without early chip select");
   dout_idle_a: assert property (cs_n && $past(cs_n, 6) |-> !dout)
      else $error("dout not idle between frames");
   dout_edge_a: assert property ($changed(dout) && !cs_n |->
      !$past(sclk, 3) && $past(sclk, 7)) else $error("dout moved away from a falling sclk");
   cfg_hold_a: assert property (cs_n && $past(cs_n, 8) |-> $stable(cfg))
      else $error("cfg changed outside a frame");
endmodule
bind adc_fifo_serial adc_fifo_serial_checker adc_fifo_serial_checker_inst (.clk, .rstn, .cs_n,
   .sclk, .din, .dout, .eoc_n, .convert_start_input_n, .core_valid, .core_ready, .core_data,
   .scan_done, .scan_abort, .cfg);

// file: testbench/spi_host_model.sv
// Purpose: serial host that frames reads and command writes
// Assumes: mode-0 timing, half period of 8 clk, low phase stretched
// Notes:   sclk rests low between frames; din flips when released
`timescale 1ns/100ps
module spi_host_model
(
   input  wire logic clk,
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // msb first; rx takes the bit shown after each fall, upper 4 bits are not code
   task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      tk(1);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         din = tx[15-i];
         tk(8);
         sclk = 1'b1;
         tk(8);
         sclk = 1'b0;
         tk(8);
         rx = {rx[14:0], dout};
      end
      cs_n = 1'b1;
      din = ~din;
      tk(8);
   endtask
endmodule

// file: testbench/tb_adc_fifo_partial_transfer.sv
// Purpose: self-checking bench for partial reads, commands and buffering
// Assumes: host waits for eoc_n low before each frame except the abort case
// Notes:   abort_seen never clears once an aborted frame sets it, so that case runs last
`timescale 1ns/100ps
module tb_adc_fifo_partial_transfer
   import adc_fifo_pkg::*;
;
   logic                     clk = 1'b0;
   logic                     rstn = 1'b0;
   logic                     cs_n, sclk, din, dout, eoc_n, core_ready, scan_abort;
   logic                     core_valid = 1'b0;
   logic                     scan_done = 1'b0;
   logic                     abort_seen = 1'b0;
   result_t                  core_data = '0;
   logic [CFG_REGS-1:0][7:0] cfg;
   int                       num_errors = 0;
   int                       comparisons = 0;
   localparam logic [11:0]   TC = 12'(25000 / TEMP_MDEG_LSB);
   localparam logic [11:0]   VC [4] = '{12'(VREF_STEPS / 2), 12'(VREF_STEPS - 1), 12'h001,
                                        12'hA5C};
   always #5 clk = ~clk;
   always @(posedge clk) if (scan_abort === 1'b1) abort_seen <= 1'b1;
   adc_fifo_serial adc_fifo_serial_inst (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
      .din(din), .dout(dout), .eoc_n(eoc_n), .convert_start_input_n(1'b1),
      .core_valid(core_valid), .core_ready(core_ready), .core_data(core_data),
      .scan_done(scan_done), .scan_abort(scan_abort), .cfg(cfg));
   spi_host_model spi_host_model_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // bounded wait; a refusal shows as ok low
   task automatic push(input logic t, input logic [11:0] c, output logic ok);
      tick(1);
      ok = 1'b0;
      core_valid = 1'b1;
      core_data = '{t, c};
      // ready is read off the edge, so the value seen is the one the next edge takes
      for (int n = 0; n < 10 && !ok; n++)
      begin
         ok = (core_ready === 1'b1);
         tick(1);
      end
      core_valid = 1'b0;
   endtask
   // end of scan first, so chip select never falls while a scan runs
   task automatic rd(input int n, input logic [15:0] tx, output logic [15:0] rx);
      scan_done = 1'b1;
      tick(1);
      scan_done = 1'b0;
      tick(2);
      chk("eoc_n low", 0, eoc_n);
      spi_host_model_inst.xfer(n, tx, rx);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_scan();
      logic        ok;
      logic [15:0] rx;
      push(1'b1, TC, ok);
      for (int i = 0; i < 4; i++) push(1'b0, VC[i], ok);
      rd(16, 16'h0000, rx);
      chk("temp first", 32'(TC), rx);
      chk("eoc_n high", 1, eoc_n);
      rd(5, 16'h0000, rx);
      rd(8, 16'h0000, rx);
      chk("tail byte", 32'(VC[0][7:0]), rx);
      rd(16, 16'h0000, rx);
      chk("after tail", 32'(VC[1]), rx);
      rd(12, 16'h0000, rx);
      chk("upper bits", 32'(VC[2][11:4]), rx);
      rd(16, 16'h0000, rx);
      chk("after cut", 32'(VC[3]), rx);
   endtask
   task automatic t_fill();
      logic        ok;
      logic [15:0] rx;
      int          cnt;
      cnt = 0;
      for (int i = 0; i < FIFO_DEPTH + 3; i++)
      begin
         push(1'b0, 12'(i), ok);
         cnt += int'(ok);
      end
      chk("accepted", FIFO_DEPTH + 2, cnt);
      for (int i = 0; i < FIFO_DEPTH + 2; i++)
      begin
         rd(16, 16'h0000, rx);
         chk("drain", i, rx);
      end
   endtask
   task automatic t_cmd();
      logic        ok;
      logic [15:0] rx;
      for (int b = 1; b >= 0; b--)
      begin
         push(1'b0, 12'h111, ok);
         push(1'b0, 12'h222, ok);
         rd(8, {CMD_RST_TAG, b[0], 11'h000}, rx);
         push(1'b0, 12'h5A5, ok);
         rd(16, 16'h0000, rx);
         chk("after clear", 32'h0000_05A5, rx);
         chk("cfg kept", b[0] ? 32'h0000_008F : 32'h0000_0000, cfg[2]);
      end
      chk("cfg", 32'h0000_0000, cfg);
   endtask
   // full byte into register 2, then four bits over its upper half
   task automatic t_write();
      logic [15:0] rx;
      rd(8, 16'hBF00, rx);
      chk("cfg full", 32'h0000_00BF, cfg[2]);
      rd(4, 16'h8000, rx);
      chk("cfg part", 32'h0000_008F, cfg[2]);
   endtask
   task automatic t_abort();
      logic [15:0] rx;
      chk("no abort", 0, abort_seen);
      spi_host_model_inst.xfer(8, 16'h0000, rx);
      chk("abort", 1, abort_seen);
   endtask
   initial
   begin
      tick(3);
      rstn = 1'b1;
      tick(4);
      chk("reset", 32'h0000_0001, {dout, cfg[1:0], eoc_n});
      t_scan();
      t_fill();
      t_write();
      t_cmd();
      t_abort();
      end_of_test();
   end
endmodule
